// ===== bench/adc_sequencer_and_event_flags_test.sv
`timescale 1ns/1ps
`default_nettype none
// Compare a seen value with the expected one and count the outcome.
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin fails++; \
  $display("ERROR %s expected %h seen %h", what, exp, got); end end

module adc_sequencer_and_event_flags_test
  import adcsq_pkg::*;
;
  logic                core_clk_i = 1'b0;
  logic                reset_i, psel_i, penable_i, pwrite_i, xtal_source_i;
  logic                pready_o, pslverr_o, irq_o, err_q;
  logic [15:0]         paddr_i, pos_code_i, neg_code_i;
  logic [31:0]         pwdata_i, prdata_o, rd_q;
  adcsq_conv_ctrl_type conv_ctrl_o;
  adcsq_buf_wr_type    buf_wr_o;
  int                  fails = 0, n_tests = 0, cyc = 0, t, t0;

  // Design under test.
  adcsq_top DUT (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .pos_code_i(pos_code_i),
    .neg_code_i(neg_code_i), .xtal_source_i(xtal_source_i), .conv_ctrl_o(conv_ctrl_o),
    .buf_wr_o(buf_wr_o), .irq_o(irq_o)
  );

  // Clock, cycle count and hang limit.
  always #10 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      end_of_test();
    end
  end

  // One bus transfer: setup, access held until ready is sampled high.
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    rd_q = prdata_o;
    err_q = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task automatic rd(input logic [15:0] a); apb(1'b0, a, 32'h0); endtask
  task automatic idle(input int n); repeat (n) @(posedge core_clk_i); endtask

  // Wait for the next result write; its cycle lands in t.
  task automatic wait_wr();
    do @(posedge core_clk_i); while (buf_wr_o.valid !== 1'b1);
    t = cyc;
  endtask

  // Reset values, refused address and the select bits.
  task automatic t_regs();
    rd(ADDR_CFG);
    `CHK("cfg reset", 32'h0000_1800, rd_q)
    rd(ADDR_GAIN);
    `CHK("gain reset", 32'h0000_8000, rd_q)
    rd(16'h1234);
    `CHK("unmapped err", 1'b1, err_q)
    wr(ADDR_CFG, 32'h0000_1006);
    idle(1);
    `CHK("pos sel", 1'b1, conv_ctrl_o.pos_input_buffer_select)
    `CHK("neg sel", 1'b0, conv_ctrl_o.neg_input_buffer_select)
    `CHK("slow sel", 1'b1, conv_ctrl_o.slow_sample_clock_select)
    wr(ADDR_CFG, 32'h0000_0802);
    idle(1);
    `CHK("neg sel", 1'b1, conv_ctrl_o.neg_input_buffer_select)
    `CHK("fast sel", 1'b0, conv_ctrl_o.slow_sample_clock_select)
    rd(ADDR_CFG);
    `CHK("cfg rsv bit", 32'h0000_0800, rd_q)
  endtask

  // Overflow with no transfer, masking, clearing and the line enable.
  task automatic t_ovf();
    wr(ADDR_MASK, 32'h0);
    wr(ADDR_IRQSET, 32'h1);
    wr(ADDR_CFG, 32'h1);
    t0 = cyc;
    do rd(ADDR_FLAG); while (rd_q[4] !== 1'b1 && cyc - t0 < 3000);
    `CHK("ovf flag", 32'h0000_0010, rd_q)
    `CHK("ovf time", 1'b1, (cyc - t0) inside {[1570:1650]})
    `CHK("irq masked", 1'b0, irq_o)
    wr(ADDR_CFG, 32'h0);
    idle(10);
    wr(ADDR_MASK, 32'h0000_0010);
    idle(2);
    `CHK("irq unmasked", 1'b1, irq_o)
    wr(ADDR_FLAG, 32'h0);
    rd(ADDR_FLAG);
    `CHK("w0 keeps", 32'h0000_0010, rd_q)
    wr(ADDR_IRQCLR, 32'h1);
    idle(2);
    `CHK("irq cleared", 1'b0, irq_o)
    wr(ADDR_IRQSET, 32'h1);
    idle(2);
    `CHK("irq set", 1'b1, irq_o)
    rd(ADDR_DMASTAT);
    `CHK("dma ovf", 32'h0000_0002, rd_q)
    wr(ADDR_FLAG, 32'h0000_0010);
    rd(ADDR_FLAG);
    `CHK("w1 clears", 32'h0, rd_q)
    `CHK("irq drops", 1'b0, irq_o)
    wr(ADDR_MASK, 32'h0);
  endtask

  // Linear two-word buffer with the positive buffer selected.
  task automatic t_dma();
    wr(ADDR_DMACFG, 32'h10);
    wr(ADDR_BEG, 32'h101);
    wr(ADDR_LEN, 32'h2);
    wr(ADDR_DMACFG, 32'h1);
    pos_code_i <= 16'h4000;
    wr(ADDR_CFG, 32'h1001);
    t0 = cyc;
    wait_wr();
    `CHK("first lat", 1'b1, (t - t0) inside {[1570:1640]})
    `CHK("data", 16'h1000, buf_wr_o.data)
    `CHK("addr0", 13'h0100, buf_wr_o.addr)
    t0 = t;
    rd(ADDR_FLAG);
    `CHK("half", 32'h2, rd_q)
    wait_wr();
    `CHK("spacing", 1'b1, (t - t0) inside {[262:272]})
    `CHK("addr1", 13'h0102, buf_wr_o.addr)
    rd(ADDR_FLAG);
    `CHK("full", 32'h6, rd_q)
    rd(ADDR_DMASTAT);
    `CHK("stopped", 32'h0, rd_q)
    idle(300);
    rd(ADDR_DMASTAT);
    `CHK("late ovf", 32'h2, rd_q)
  endtask

  // Saturation in wrap mode, restarts on rewrite and on oscillator switch.
  task automatic t_sat();
    pos_code_i <= 16'h7800;
    wr(ADDR_GAIN, 32'hFFFF);
    wr(ADDR_CFG, 32'h2001);
    t0 = cyc;
    wr(ADDR_DMACFG, 32'h10);
    wr(ADDR_LEN, 32'h1);
    wr(ADDR_DMACFG, 32'h3);
    wr(ADDR_FLAG, 32'h1E);
    wait_wr();
    `CHK("restart lat", 1'b1, (t - t0) inside {[1050:1095]})
    `CHK("clamp", 16'h7FFF, buf_wr_o.data)
    `CHK("wrap addr", 13'h0100, buf_wr_o.addr)
    rd(ADDR_FLAG);
    `CHK("sat full", 32'hC, rd_q & 32'hE)
    wr(ADDR_CFG, 32'h2001);
    t0 = cyc;
    rd(ADDR_DMASTAT);
    `CHK("still active", 32'h1, rd_q)
    wait_wr();
    `CHK("rewrite lat", 1'b1, (t - t0) inside {[1050:1095]})
    t0 = t;
    wait_wr();
    `CHK("period1", 1'b1, (t - t0) inside {[528:540]})
    xtal_source_i <= 1'b1;
    t0 = cyc;
    wait_wr();
    `CHK("osc switch", 1'b1, (t - t0) inside {[1050:1100]})
    wr(ADDR_CFG, 32'h0);
  endtask

  // Final report and verdict.
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    reset_i = 1'b1;
    {psel_i, penable_i, pwrite_i, xtal_source_i} = 4'h0;
    {paddr_i, pos_code_i, neg_code_i} = 48'h0;
    pwdata_i = 32'h0;
    repeat (10) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(posedge core_clk_i);
    t_regs();
    t_ovf();
    t_dma();
    t_sat();
    end_of_test();
  end
endmodule // adc_sequencer_and_event_flags_test
`default_nettype wire

// ===== bench/adcsq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module adcsq_asserts
  import adcsq_pkg::*;
(
  // Clock and reset.
  input wire logic                core_clk_i,
  input wire logic                reset_i,
  // Register bus.
  input wire logic                psel_i,
  input wire logic                penable_i,
  input wire logic                pwrite_i,
  input wire logic [15:0]         paddr_i,
  input wire logic [31:0]         pwdata_i,
  input wire logic [31:0]         prdata_o,
  input wire logic                pready_o,
  input wire logic                pslverr_o,
  // Converter, buffer and interrupt.
  input wire adcsq_conv_ctrl_type conv_ctrl_o,
  input wire adcsq_buf_wr_type    buf_wr_o,
  input wire logic                irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic [11:0] on_cnt_ff;
  logic [5:0]  gap_cnt_ff;

  // Cycles since the converter was enabled, saturating.
  always_ff @(posedge core_clk_i) begin
    if (reset_i || !conv_ctrl_o.enable) on_cnt_ff <= 12'h000;
    else if (on_cnt_ff != 12'hFFF) on_cnt_ff <= on_cnt_ff + 12'h001;
  end
  // Cycles since the previous sample tick, saturating.
  always_ff @(posedge core_clk_i) begin
    if (reset_i || conv_ctrl_o.sample_tick) gap_cnt_ff <= 6'h00;
    else if (gap_cnt_ff != 6'h3F) gap_cnt_ff <= gap_cnt_ff + 6'h01;
  end

  // Bus answers come two cycles after setup, as one-cycle pulses.
  property p_ready_two; psel_i && !penable_i |-> ##2 pready_o; endproperty
  a_ready_two: assert property (p_ready_two) else $error("bus answer mistimed");
  property p_ready_pulse; pready_o |=> !pready_o; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
  property p_err_ready; pslverr_o |-> pready_o; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_rdata_idle; !pready_o |-> prdata_o == 32'h0000_0000; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
  // A clear-register write drops the interrupt line.
  property p_irq_clear;
    pready_o && pwrite_i && paddr_i == ADDR_IRQCLR && pwdata_i[0] |-> ##2 !irq_o;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq stays after clear");
  // Results and ticks are single pulses tied to an enabled converter.
  property p_wr_pulse; buf_wr_o.valid |=> !buf_wr_o.valid; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("buffer write too long");
  property p_tick_on; conv_ctrl_o.sample_tick |-> conv_ctrl_o.enable; endproperty
  a_tick_on: assert property (p_tick_on) else $error("tick while disabled");
  property p_tick_gap; conv_ctrl_o.sample_tick |-> gap_cnt_ff >= 6'h07; endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("sample ticks too close");
  // Startup delay before ticks and before the first result.
  property p_tick_warm; conv_ctrl_o.sample_tick |-> on_cnt_ff >= STARTUP_CYC - 2; endproperty
  a_tick_warm: assert property (p_tick_warm) else $error("tick during warm-up");
  property p_first_late; buf_wr_o.valid |-> on_cnt_ff >= STARTUP_CYC + 500; endproperty
  a_first_late: assert property (p_first_late) else $error("first result too early");
  // Main scenarios reached.
  c_result: cover property (buf_wr_o.valid);
  c_refused: cover property (pslverr_o);
  c_irq: cover property ($rose(irq_o));
endmodule // adcsq_asserts

bind adcsq_top adcsq_asserts u_adcsq_asserts (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .conv_ctrl_o(conv_ctrl_o),
  .buf_wr_o(buf_wr_o), .irq_o(irq_o)
);
`default_nettype wire

// ===== hdl/adcsq_pkg.sv
// Contract
// RULE_01: A selected input buffer scales that input by one quarter before conversion.
// RULE_02: Configuration holds separate buffer-enable bits for positive and negative inputs.
// RULE_03: Clock-select clear picks 6 MHz sampling, set picks 1 MHz.
// RULE_04: Period field gives 32 shifted left by field sampling clocks per sample.
// RULE_05: Results are 16-bit words holding 5 plus field significant bits left-aligned.
// RULE_06: Sample timing does not depend on which processor oscillator runs.
// RULE_07: With enable set, conversions run back to back until enable clears.
// RULE_08: Enabling a disabled converter waits 21 us before conversions start.
// RULE_09: After enable or configuration write, the first conversion is dropped.
// RULE_10: Processor clock source switch repeats the discard-first-conversion cycle.
// RULE_11: First result after enable comes after startup delay plus doubled sample.
// RULE_12: Configuration writes never stop the running result transfer.
// RULE_13: A result ready while transfer is inactive sets the overflow flag.
// RULE_14: Gain product outside signed 16-bit range sets the saturation flag.
// RULE_15: Writing the last buffer location sets the buffer-full flag.
// RULE_16: Writing the last location of the lower half sets half-full.
// RULE_17: Writing one to a flag clears it; zero leaves it.
// RULE_18: A flag requests the interrupt only while its mask bit is one.
// RULE_19: Interrupt line enabled through a set register, disabled through a clear register.
// RULE_20: Polling software writes zero to the mask and reads the flags.
// RULE_21: Software stops transfer before reconfiguring, then clears overflow after restart.
// RULE_22: Single polled sample uses a one-word buffer, wrap mode, full flag.
// RULE_23: Gain result clamps to 7FFF or 8000 and raises saturation.
// RULE_24: Linear mode stops after the programmed count and raises buffer-full.
// RULE_25: A flag set in the same cycle as its clear stays set.
package adcsq_pkg;

  // Clock rates and startup timing.
  localparam int CORE_MHZ      = 50;
  localparam int FAST_MHZ      = 6;
  localparam int SLOW_MHZ      = 1;
  localparam int ACC_W         = 6;
  localparam int CLK_PERIOD_NS = 20;
  localparam int STARTUP_NS    = 21000;
  localparam int STARTUP_CYC   = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_W     = 11;

  // Register byte addresses.
  localparam logic [15:0] ADDR_CFG     = 16'hD004;
  localparam logic [15:0] ADDR_OFFSET  = 16'hD008;
  localparam logic [15:0] ADDR_GAIN    = 16'hD00C;
  localparam logic [15:0] ADDR_DMACFG  = 16'hD010;
  localparam logic [15:0] ADDR_DMASTAT = 16'hD014;
  localparam logic [15:0] ADDR_BEG     = 16'hD018;
  localparam logic [15:0] ADDR_LEN     = 16'hD01C;
  localparam logic [15:0] ADDR_CUR     = 16'hD020;
  localparam logic [15:0] ADDR_CNT     = 16'h0000;
  localparam logic [15:0] ADDR_FLAG    = 16'hA810;
  localparam logic [15:0] ADDR_MASK    = 16'hA850;
  localparam logic [15:0] ADDR_IRQSET  = 16'hA860;
  localparam logic [15:0] ADDR_IRQCLR  = 16'hA864;

  // Configuration fields and reset values.
  localparam int CFG_EN_BIT   = 0;
  localparam int CFG_RSV_BIT  = 1;
  localparam int CFG_SLOW_BIT = 2;
  localparam int CFG_NEG_BIT  = 11;
  localparam int CFG_POS_BIT  = 12;
  localparam int CFG_PER_LSB  = 13;
  localparam logic [15:0] CFG_RESET    = 16'h1800;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [15:0] GAIN_RESET   = 16'h8000;
  localparam int GAIN_FRAC    = 15;
  localparam int BASE_SIG     = 5;
  localparam logic [12:0] MIN_CLKS = 13'h0020;

  // Transfer engine fields.
  localparam int DMA_LOAD_BIT = 0;
  localparam int DMA_WRAP_BIT = 1;
  localparam int DMA_RST_BIT  = 4;
  localparam logic [12:0] ADDR_STEP = 13'h0002;

  // Event flag positions.
  localparam int FLG_HALF = 1;
  localparam int FLG_FULL = 2;
  localparam int FLG_SAT  = 3;
  localparam int FLG_OVF  = 4;

  // Saturation limits.
  localparam logic [15:0] SAT_MAX = 16'h7FFF;
  localparam logic [15:0] SAT_MIN = 16'h8000;

  // Sequencer states.
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_WARM    = 4'h2,
    ST_DISCARD = 4'h4,
    ST_RUN     = 4'h8
  } adcsq_state_type;

  // Controls toward the analog converter.
  typedef struct packed {
    logic enable;
    logic pos_input_buffer_select;
    logic neg_input_buffer_select;
    logic slow_sample_clock_select;
    logic sample_tick;
  } adcsq_conv_ctrl_type;

  // One write into the result buffer memory.
  typedef struct packed {
    logic        valid;
    logic [12:0] addr;
    logic [15:0] data;
  } adcsq_buf_wr_type;

  // Clamp to signed 16 bits; the top bit reports a clamp.
  function automatic logic [16:0] sat16(input logic signed [35:0] v);
    if (v > $signed(36'(SAT_MAX))) begin
      return {1'h1, SAT_MAX};
    end else if (v < -$signed(36'(SAT_MIN))) begin
      return {1'h1, SAT_MIN};
    end
    return {1'h0, v[15:0]};
  endfunction

endpackage

// ===== hdl/adcsq_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module adcsq_tick_gen
  import adcsq_pkg::*;
(
  // Clock and reset.
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  // Rate select and enable out.
  input  wire logic slow_i,
  output logic      tick_o
);

  logic [ACC_W-1:0] acc_ff;
  logic [ACC_W-1:0] nxt_acc;
  logic [ACC_W:0]   sum_w;
  logic             wrap_w;

  // Fractional divider adds the sample rate each core cycle and wraps at the core rate.
  // RULE_03 rate select
  assign sum_w   = {1'h0, acc_ff} + (slow_i ? (ACC_W+1)'(SLOW_MHZ) : (ACC_W+1)'(FAST_MHZ));
  assign wrap_w  = sum_w >= (ACC_W+1)'(CORE_MHZ);
  assign nxt_acc = wrap_w ? ACC_W'(sum_w - (ACC_W+1)'(CORE_MHZ)) : ACC_W'(sum_w);

  // The enable is derived from the core clock alone, whatever oscillator feeds the CPU.
  // RULE_06 oscillator independent
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      acc_ff <= '0;
      tick_o <= 1'h0;
    end else begin
      acc_ff <= nxt_acc;
      tick_o <= wrap_w;
    end
  end

endmodule // adcsq_tick_gen
`default_nettype wire

// ===== hdl/adcsq_top.sv
`timescale 1ns/1ps
`default_nettype none
module adcsq_top
  import adcsq_pkg::*;
(
  // Clock and reset.
  input  wire logic                 core_clk_i,
  input  wire logic                 reset_i,
  // APB slave.
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [15:0]          paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  // Converter side.
  input  wire logic [15:0]          pos_code_i,
  input  wire logic [15:0]          neg_code_i,
  input  wire logic                 xtal_source_i,
  output adcsq_conv_ctrl_type       conv_ctrl_o,
  // Result buffer write port.
  output adcsq_buf_wr_type          buf_wr_o,
  // Processor interrupt.
  output logic                      irq_o
);

  // Register state.
  logic [15:0]     cfg_ff;
  logic [15:0]     offset_ff;
  logic [15:0]     gain_ff;
  logic            wrap_ff;
  logic            act_ff;
  logic            dovf_ff;
  logic [12:0]     beg_ff;
  logic [11:0]     len_ff;
  logic [12:0]     cur_ff;
  logic [11:0]     cnt_ff;
  logic [4:1]      flags_ff;
  logic [4:1]      mask_ff;
  logic            irq_en_ff;
  // Sequencer state.
  adcsq_state_type state_ff;
  adcsq_state_type nxt_state;
  logic [STARTUP_W-1:0] warm_ff;
  logic [12:0]     scnt_ff;
  // Input synchronisers.
  logic [15:0]     pos_s1_ff;
  logic [15:0]     pos_s2_ff;
  logic [15:0]     neg_s1_ff;
  logic [15:0]     neg_s2_ff;
  logic            xtal_s1_ff;
  logic            xtal_s2_ff;
  logic            xtal_s3_ff;
  // Result stage.
  logic            res_vld_ff;
  logic [15:0]     res_ff;
  logic            sat_ff;

  // Bus handshake: one wait state, then the access completes.
  logic acc_prep, wr_en;
  assign acc_prep = psel_i & penable_i & ~pready_o;
  assign wr_en    = psel_i & penable_i & pready_o & pwrite_i;

  // Address decode.
  logic hit_cfg, hit_off, hit_gain, hit_dcfg, hit_dstat, hit_beg, hit_len;
  logic hit_cur, hit_cnt, hit_flag, hit_mask, hit_iset, hit_iclr, hit_any;
  assign hit_cfg   = paddr_i == ADDR_CFG;
  assign hit_off   = paddr_i == ADDR_OFFSET;
  assign hit_gain  = paddr_i == ADDR_GAIN;
  assign hit_dcfg  = paddr_i == ADDR_DMACFG;
  assign hit_dstat = paddr_i == ADDR_DMASTAT;
  assign hit_beg   = paddr_i == ADDR_BEG;
  assign hit_len   = paddr_i == ADDR_LEN;
  assign hit_cur   = paddr_i == ADDR_CUR;
  assign hit_cnt   = paddr_i == ADDR_CNT;
  assign hit_flag  = paddr_i == ADDR_FLAG;
  assign hit_mask  = paddr_i == ADDR_MASK;
  assign hit_iset  = paddr_i == ADDR_IRQSET;
  assign hit_iclr  = paddr_i == ADDR_IRQCLR;
  assign hit_any   = hit_cfg | hit_off | hit_gain | hit_dcfg | hit_dstat | hit_beg | hit_len
                   | hit_cur | hit_cnt | hit_flag | hit_mask | hit_iset | hit_iclr;

  // Write strobes per register.
  logic cfg_wr, dcfg_wr, dma_rst, dma_load, new_en;
  assign cfg_wr   = wr_en & hit_cfg;
  assign dcfg_wr  = wr_en & hit_dcfg;
  assign dma_rst  = dcfg_wr & pwdata_i[DMA_RST_BIT];
  assign dma_load = dcfg_wr & pwdata_i[DMA_LOAD_BIT] & ~pwdata_i[DMA_RST_BIT];
  assign new_en   = pwdata_i[CFG_EN_BIT];

  // Read data selection; reserved bits read as zero.
  logic [31:0] rd_w;
  assign rd_w = hit_cfg   ? {16'h0000, cfg_ff}
              : hit_off   ? {16'h0000, offset_ff}
              : hit_gain  ? {16'h0000, gain_ff}
              : hit_dcfg  ? {30'h0, wrap_ff, 1'h0}
              : hit_dstat ? {30'h0, dovf_ff, act_ff}
              : hit_beg   ? {19'h0, beg_ff}
              : hit_len   ? {20'h0, len_ff}
              : hit_cur   ? {19'h0, cur_ff}
              : hit_cnt   ? {20'h0, cnt_ff}
              : hit_flag  ? {27'h0, flags_ff, 1'h0}
              : hit_mask  ? {27'h0, mask_ff, 1'h0}
              : (hit_iset | hit_iclr) ? {31'h0, irq_en_ff}
              : 32'h0000_0000;

  // Bus answer registers; unmapped addresses answer with an error.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pready_o  <= 1'h0;
      pslverr_o <= 1'h0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= acc_prep;
      pslverr_o <= acc_prep & ~hit_any;
      prdata_o  <= acc_prep ? rd_w : 32'h0000_0000;
    end
  end

  // Configuration, correction and mask registers.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cfg_ff    <= CFG_RESET;
      offset_ff <= OFFSET_RESET;
      gain_ff   <= GAIN_RESET;
      mask_ff   <= '0;
      irq_en_ff <= 1'h0;
    end else begin
      // RULE_02 two buffer bits
      if (cfg_wr) begin
        cfg_ff <= pwdata_i[15:0] & ~(16'h0001 << CFG_RSV_BIT);
      end
      if (wr_en & hit_off) begin
        offset_ff <= pwdata_i[15:0];
      end
      if (wr_en & hit_gain) begin
        gain_ff <= pwdata_i[15:0];
      end
      if (wr_en & hit_mask) begin
        mask_ff <= pwdata_i[FLG_OVF:FLG_HALF];
      end
      // RULE_19 set and clear
      if (wr_en & hit_iset & pwdata_i[0]) begin
        irq_en_ff <= 1'h1;
      end else if (wr_en & hit_iclr & pwdata_i[0]) begin
        irq_en_ff <= 1'h0;
      end
    end
  end

  // Two-stage synchronisers for converter codes and oscillator source.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      {pos_s1_ff, pos_s2_ff, neg_s1_ff, neg_s2_ff} <= 64'h0;
      {xtal_s1_ff, xtal_s2_ff, xtal_s3_ff} <= 3'h0;
    end else begin
      pos_s1_ff  <= pos_code_i;
      pos_s2_ff  <= pos_s1_ff;
      neg_s1_ff  <= neg_code_i;
      neg_s2_ff  <= neg_s1_ff;
      xtal_s1_ff <= xtal_source_i;
      xtal_s2_ff <= xtal_s1_ff;
      xtal_s3_ff <= xtal_s2_ff;
    end
  end

  // Sampling clock enable at 6 MHz or 1 MHz.
  logic tick_w;
  adcsq_tick_gen u_tick (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .slow_i     (cfg_ff[CFG_SLOW_BIT]),
    .tick_o     (tick_w)
  );

  // Sample length and end of sample.
  logic [2:0]  per_w;
  logic [12:0] cps_w;
  logic        samp_end, xtal_chg, warm_done;
  assign per_w     = cfg_ff[CFG_PER_LSB +: 3];
  // RULE_04 clocks per sample
  assign cps_w     = MIN_CLKS << per_w;
  assign samp_end  = tick_w & (scnt_ff == cps_w - 13'h0001);
  assign xtal_chg  = xtal_s2_ff ^ xtal_s3_ff;
  assign warm_done = warm_ff == STARTUP_W'(STARTUP_CYC - 1);

  // Sequencer next state.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        // RULE_08 startup delay
        if (cfg_wr & new_en) begin
          nxt_state = ST_WARM;
        end
      end
      ST_WARM: begin
        // RULE_11 delay then discard
        if (warm_done) begin
          nxt_state = ST_DISCARD;
        end
      end
      ST_DISCARD: begin
        // RULE_09 drop first conversion
        if (samp_end) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        // RULE_09 restart on config
        // RULE_10 restart on oscillator
        if ((cfg_wr & new_en) | xtal_chg) begin
          nxt_state = ST_DISCARD;
        end
      end
    endcase
    // RULE_07 run until disabled
    if (cfg_wr & ~new_en) begin
      nxt_state = ST_IDLE;
    end else if (state_ff == ST_DISCARD && ((cfg_wr & new_en) | xtal_chg)) begin
      nxt_state = ST_DISCARD;
    end
  end

  // Sequencer registers; a new discard sample restarts the sample count.
  logic restart;
  assign restart = (nxt_state == ST_DISCARD) &&
                   (state_ff != ST_DISCARD || cfg_wr || xtal_chg);
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_ff <= ST_IDLE;
      warm_ff  <= '0;
      scnt_ff  <= 13'h0000;
    end else begin
      state_ff <= nxt_state;
      warm_ff  <= (state_ff == ST_WARM) ? warm_ff + STARTUP_W'(1) : '0;
      if (restart || samp_end || nxt_state == ST_IDLE || nxt_state == ST_WARM) begin
        scnt_ff <= 13'h0000;
      end else if (tick_w) begin
        scnt_ff <= scnt_ff + 13'h0001;
      end
    end
  end

  // Conversion value: quarter scaling per buffered input, then left-aligned.
  logic signed [15:0] pa_w, na_w;
  logic signed [35:0] diff_w, sum_w, prod_w, scaled_w;
  logic [16:0]        dsat_w, gsat_w;
  logic [15:0]        mask_w, raw_w;
  // RULE_01 quarter gain
  assign pa_w   = cfg_ff[CFG_POS_BIT] ? $signed(pos_s2_ff) >>> 2 : $signed(pos_s2_ff);
  assign na_w   = cfg_ff[CFG_NEG_BIT] ? $signed(neg_s2_ff) >>> 2 : $signed(neg_s2_ff);
  assign diff_w = 36'(pa_w) - 36'(na_w);
  assign dsat_w = sat16(diff_w);
  // RULE_05 left-aligned bits
  assign mask_w = ~(16'hFFFF >> (BASE_SIG + int'(per_w)));
  assign raw_w  = dsat_w[15:0] & mask_w;

  // Offset then gain correction with clamping.
  assign sum_w    = 36'($signed(raw_w)) + 36'($signed(offset_ff));
  assign prod_w   = sum_w * $signed({20'h0, gain_ff});
  assign scaled_w = prod_w >>> GAIN_FRAC;
  // RULE_23 clamp result
  assign gsat_w   = sat16(scaled_w);

  // Result stage: one result per kept sample.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      res_vld_ff <= 1'h0;
      res_ff     <= 16'h0000;
      sat_ff     <= 1'h0;
    end else begin
      res_vld_ff <= samp_end && state_ff == ST_RUN && !cfg_wr && !xtal_chg;
      res_ff     <= gsat_w[15:0];
      sat_ff     <= samp_end && state_ff == ST_RUN && !cfg_wr && !xtal_chg && gsat_w[16];
    end
  end

  // Buffer position arithmetic.
  logic [11:0] cnt_nxt, half_w;
  logic        at_full, at_half, store;
  assign cnt_nxt = cnt_ff + 12'h001;
  assign half_w  = {1'h0, len_ff[11:1]};
  assign at_full = cnt_nxt == len_ff;
  assign at_half = (cnt_nxt == half_w) && (half_w != 12'h000);
  assign store   = res_vld_ff & act_ff;

  // Transfer engine; configuration writes do not touch it.
  // RULE_12 transfer continues
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wrap_ff <= 1'h0;
      act_ff  <= 1'h0;
      dovf_ff <= 1'h0;
      beg_ff  <= 13'h0000;
      len_ff  <= 12'h000;
      cur_ff  <= 13'h0000;
      cnt_ff  <= 12'h000;
    end else begin
      if (wr_en & hit_beg) begin
        beg_ff <= pwdata_i[12:0] & 13'h1FFE;
      end
      if (wr_en & hit_len) begin
        len_ff <= pwdata_i[11:0];
      end
      if (dcfg_wr) begin
        wrap_ff <= pwdata_i[DMA_WRAP_BIT];
      end
      if (dma_rst | dma_load) begin
        act_ff  <= dma_load;
        dovf_ff <= dma_load & dovf_ff;
        cur_ff  <= beg_ff;
        cnt_ff  <= 12'h000;
      end else if (store && at_full) begin
        // RULE_24 linear stop
        act_ff <= wrap_ff;
        cur_ff <= beg_ff;
        cnt_ff <= wrap_ff ? 12'h000 : cnt_nxt;
      end else if (store) begin
        cur_ff <= cur_ff + ADDR_STEP;
        cnt_ff <= cnt_nxt;
      end else if (res_vld_ff) begin
        dovf_ff <= 1'h1;
      end
    end
  end

  // Hardware events for the flag register.
  logic [4:1] fl_set, fl_clr;
  // RULE_13 overflow event
  assign fl_set[FLG_OVF]  = res_vld_ff & ~act_ff;
  // RULE_14 saturation event
  assign fl_set[FLG_SAT]  = sat_ff;
  // RULE_15 full event
  assign fl_set[FLG_FULL] = store & at_full;
  // RULE_16 half event
  assign fl_set[FLG_HALF] = store & at_half;
  // RULE_17 write one clears
  assign fl_clr = (wr_en & hit_flag) ? pwdata_i[FLG_OVF:FLG_HALF] : 4'h0;

  // Flags, buffer write port, converter controls and interrupt.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      flags_ff    <= 4'h0;
      buf_wr_o    <= '0;
      conv_ctrl_o <= '0;
      irq_o       <= 1'h0;
    end else begin
      // RULE_25 set wins
      flags_ff    <= (flags_ff & ~fl_clr) | fl_set;
      buf_wr_o    <= '{valid: store, addr: cur_ff, data: res_ff};
      conv_ctrl_o <= '{enable: state_ff != ST_IDLE,
                       pos_input_buffer_select: cfg_ff[CFG_POS_BIT],
                       neg_input_buffer_select: cfg_ff[CFG_NEG_BIT],
                       slow_sample_clock_select: cfg_ff[CFG_SLOW_BIT],
                       sample_tick: tick_w & (state_ff == ST_DISCARD || state_ff == ST_RUN)};
      // RULE_18 masked request
      irq_o       <= irq_en_ff & |(flags_ff & mask_ff);
    end
  end

endmodule // adcsq_top
`default_nettype wire
